// *** mac_receive_indication_port.sv ***
// receive indication port: delayed copy of the received symbol-pair
// stream with odd parity, sequencing strobes, match flags and
// termination events/status. assumes phy byte and byte_en are
// presented synchronous to CLK_I once per byte time.
//
// Operation
// R1: one byte with parity every 80 ns
// R2: every received byte copied to indication port
// R3: eight data bits plus one parity bit
// R4: start strobe while starting delimiter shown
// R5: frame control strobe while fc shown
// R6: dest seen from last da byte onward
// R7: source seen from last sa byte onward
// R8: info seen from fourth info byte onward
// R9: dest match flag with two qualifiers
// R10: source match flag with short/long qualifier
// R11: repeat source flag on non-mac frames
// R12: repeat payload flag on mac frames
// R13: far side buffers bytes while deciding copy
// R14: exactly one termination event per pdu
// R15: end delimiter event through frame status
// R16: token event on token ending delimiter
// R17: strip event on first idle of stripped frame
// R18: format fault event on faulty byte
// R19: reset event on controller reset or stop
// R20: length ok needs minimum and whole pairs
// R21: check sequence ok on crc residue match
// R22: external match sets a, copy valid sets c; code sets c only when a is also set
// R23: outputs active high, change on clock edge
// R24: parity odd over the eight data bits
// R25: token end shown as nibble 5 twice
// R26: flags hold until next starting delimiter
`timescale 1ns/1ps
`default_nettype none

module mac_receive_indication_port (
    // clock and reset
    input  wire logic                    CLK_I,
    input  wire logic                    RESET_I,
    // phy side byte stream
    input  wire mac_ind_pkg::phy_byte_t  PHY_BYTE_I,
    input  wire logic                    STOP_MODE_I,
    input  wire logic                    STRIP_I,
    input  wire logic                    HALF_PAIR_I,
    // station addresses
    input  wire logic [47:0]             LONG_ADDR_I,
    input  wire logic [15:0]             SHORT_ADDR_I,
    input  wire logic [47:0]             GROUP_ADDR_I,
    // external flags
    input  wire logic                    EXT_ADDR_MATCH_IN_I,
    input  wire logic                    COPY_VALID_IN_I,
    // indication data
    output var  mac_ind_pkg::ind_byte_t  IND_BYTE_O,
    output logic                         BYTE_STROBE_O,
    // sequencing
    output logic                         RX_START_STROBE_O,
    output logic                         FRAME_CONTROL_SEEN_O,
    output logic                         DEST_ADDR_SEEN_O,
    output logic                         SRC_ADDR_SEEN_O,
    output logic                         INFO_FIELD_SEEN_O,
    // flags
    output logic                         DEST_MATCH_FLAG_O,
    output logic                         SRC_MATCH_FLAG_O,
    output logic                         SHORT_LONG_SELECT_O,
    output logic                         INDIV_GROUP_SELECT_O,
    output logic                         REPEAT_SOURCE_FLAG_O,
    output logic                         REPEAT_PAYLOAD_FLAG_O,
    // termination
    output var  mac_ind_pkg::term_t      TERM_O,
    output logic                         LENGTH_OK_STATUS_O,
    output logic                         CHECK_SEQ_OK_STATUS_O,
    // outgoing indicators
    output logic                         A_IND_O,
    output logic                         C_IND_O
);

    // byte time divider
    logic [3:0]              div_r;
    logic                    byte_en;
    // R1: one byte per 80 ns byte time
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            div_r <= mac_ind_pkg::DIV_RST;
        end else if (div_r == mac_ind_pkg::DIV_LAST) begin
            div_r <= mac_ind_pkg::DIV_RST;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end
    assign byte_en = (div_r == mac_ind_pkg::DIV_LAST);

    // symbol decode of the incoming byte
    logic       c_in;
    logic [7:0] d_in;
    logic       is_jk, is_t_hi, is_tt, is_idle, is_fs, is_nt;
    assign c_in    = PHY_BYTE_I.ctrl;
    assign d_in    = PHY_BYTE_I.data;
    assign is_jk   = c_in && d_in[7:4] == mac_ind_pkg::NIB_J;
    assign is_t_hi = c_in && d_in[7:4] == mac_ind_pkg::NIB_T;
    assign is_tt   = is_t_hi && d_in[3:0] == mac_ind_pkg::NIB_T;
    assign is_nt   = c_in && d_in == {4'h0, mac_ind_pkg::NIB_T};
    assign is_idle = c_in && d_in[7:6] == mac_ind_pkg::NIB_IDLE;
    assign is_fs   = c_in && (d_in[7:4] == mac_ind_pkg::NIB_R
                     || d_in[7:4] == mac_ind_pkg::NIB_S);

    // sequencer state and counters
    mac_ind_pkg::rx_state_t state_r;
    logic [11:0] len_r;
    logic [3:0]  fld_r;
    logic [7:0]  fc_r;
    logic        addr_long;
    logic [3:0]  addr_len;
    assign addr_long = fc_r[mac_ind_pkg::FC_LONG_BIT];
    assign addr_len  = addr_long ? mac_ind_pkg::LONG_ADDR_LEN
                                 : mac_ind_pkg::SHORT_ADDR_LEN;

    // next-cycle events (computed from the byte entering the port)
    logic ev_start, ev_fc, ev_da_last, ev_sa_last, ev_info4;
    logic ev_ed, ev_tok, ev_strip, ev_fault, ev_fs;
    always_comb begin
        ev_start   = 1'b0;
        ev_fc      = 1'b0;
        ev_da_last = 1'b0;
        ev_sa_last = 1'b0;
        ev_info4   = 1'b0;
        ev_ed      = 1'b0;
        ev_tok     = 1'b0;
        ev_strip   = 1'b0;
        ev_fault   = 1'b0;
        ev_fs      = 1'b0;
        if (is_jk) begin
            ev_start = 1'b1;
        end else begin
            unique case (state_r)
                mac_ind_pkg::ST_IDLE: ;
                mac_ind_pkg::ST_FC: begin
                    if (c_in) ev_fault = 1'b1;
                    else      ev_fc    = 1'b1;
                end
                mac_ind_pkg::ST_DA, mac_ind_pkg::ST_SA,
                mac_ind_pkg::ST_INFO: begin
                    if (is_tt || is_t_hi || is_nt) begin
                        ev_ed  = 1'b1;
                    end else if (is_idle && STRIP_I) begin
                        ev_strip = 1'b1;
                    end else if (c_in) begin
                        ev_fault = 1'b1;
                    end else if (fld_r + 4'h1 == addr_len) begin
                        ev_da_last = (state_r == mac_ind_pkg::ST_DA);
                        ev_sa_last = (state_r == mac_ind_pkg::ST_SA);
                    end
                    // first fourth byte only: fld_r wraps in long info
                    if (state_r == mac_ind_pkg::ST_INFO && !c_in
                        && !INFO_FIELD_SEEN_O
                        && fld_r + 4'h1 == mac_ind_pkg::INFO_BYTES_CMP)
                        ev_info4 = 1'b1;
                end
                mac_ind_pkg::ST_STATUS: ev_fs = is_fs;
            endcase
            // a token: tt right after the starting delimiter
            if (state_r == mac_ind_pkg::ST_FC && is_tt) begin
                ev_tok   = 1'b1;
                ev_fault = 1'b0;
            end
        end
    end

    // sequencer, advanced once per byte time
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_r <= mac_ind_pkg::ST_IDLE;
            fld_r   <= 4'h0;
            len_r   <= mac_ind_pkg::COUNT_RST;
            fc_r    <= mac_ind_pkg::DATA_RST;
        end else if (STOP_MODE_I) begin
            state_r <= mac_ind_pkg::ST_IDLE;
        end else if (byte_en) begin
            len_r <= len_r + 12'h001;
            fld_r <= fld_r + 4'h1;
            if (ev_start) begin
                state_r <= mac_ind_pkg::ST_FC;
                len_r   <= mac_ind_pkg::COUNT_RST;
            end else if (ev_tok || ev_fault || ev_strip) begin
                state_r <= mac_ind_pkg::ST_IDLE;
            end else if (ev_ed) begin
                state_r <= mac_ind_pkg::ST_STATUS;
            end else if (ev_fc) begin
                state_r <= mac_ind_pkg::ST_DA;
                fld_r   <= 4'h0;
                fc_r    <= d_in;
            end else if (ev_da_last) begin
                state_r <= mac_ind_pkg::ST_SA;
                fld_r   <= 4'h0;
            end else if (ev_sa_last) begin
                state_r <= mac_ind_pkg::ST_INFO;
                fld_r   <= 4'h0;
            end else if (state_r == mac_ind_pkg::ST_STATUS && !ev_fs) begin
                state_r <= mac_ind_pkg::ST_IDLE;
            end
        end
    end

    // R23: registered, active-high outputs
    // R2: delayed copy of every byte
    // R3: eight data bits plus parity
    // R24: odd parity over data
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            IND_BYTE_O <= '{parity: 1'b1, data: mac_ind_pkg::DATA_RST};
        end else if (byte_en) begin
            IND_BYTE_O.data   <= d_in;
            IND_BYTE_O.parity <= ~(^d_in);
        end
    end
    assign BYTE_STROBE_O = byte_en;

    // R4: start strobe with delimiter
    // R5: fc strobe with frame control
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RX_START_STROBE_O    <= 1'b0;
            FRAME_CONTROL_SEEN_O <= 1'b0;
        end else if (byte_en) begin
            RX_START_STROBE_O    <= ev_start && !STOP_MODE_I;
            FRAME_CONTROL_SEEN_O <= ev_fc && !STOP_MODE_I;
        end
    end

    // address comparison shift registers
    logic [47:0] addr_sh;
    logic [31:0] info_sh, prev_sa, prev_info;
    logic [47:0] own_addr;
    logic        da_hit, sa_hit, indiv;
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            addr_sh <= 48'h0;
            info_sh <= 32'h0;
        end else if (byte_en) begin
            if (ev_fc) begin
                addr_sh <= 48'h0;
            end else if (!c_in) begin
                addr_sh <= {addr_sh[39:0], d_in};
                info_sh <= {info_sh[23:0], d_in};
            end
        end
    end
    assign own_addr = addr_long ? LONG_ADDR_I : {32'h0, SHORT_ADDR_I};
    assign indiv    = ~addr_sh[(addr_long ? 47 : 15) - 8];
    assign da_hit   = indiv
        ? ({addr_sh[39:0], d_in} == own_addr)
        : ({addr_sh[39:0], d_in} == (addr_long ? GROUP_ADDR_I
                                   : {32'h0, GROUP_ADDR_I[15:0]}));
    // short source compares two bytes only; older da bytes sit above
    assign sa_hit   = addr_long ? ({addr_sh[39:0], d_in} == LONG_ADDR_I)
                                : ({addr_sh[7:0], d_in} == SHORT_ADDR_I);

    // R6: dest seen held to next delimiter
    // R7: source seen held to next delimiter
    // R8: info seen held to next delimiter
    // R9: dest match and qualifiers
    // R10: source match flag
    // R11: repeat source on non-mac frames
    // R12: repeat payload on mac frames
    // R26: flags hold to next delimiter
    logic is_mac;
    assign is_mac = (fc_r & mac_ind_pkg::FC_MAC_MASK)
                    == mac_ind_pkg::FC_MAC_CODE;
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            DEST_ADDR_SEEN_O      <= 1'b0;
            SRC_ADDR_SEEN_O       <= 1'b0;
            INFO_FIELD_SEEN_O     <= 1'b0;
            DEST_MATCH_FLAG_O     <= 1'b0;
            SRC_MATCH_FLAG_O      <= 1'b0;
            SHORT_LONG_SELECT_O   <= 1'b0;
            INDIV_GROUP_SELECT_O  <= 1'b0;
            REPEAT_SOURCE_FLAG_O  <= 1'b0;
            REPEAT_PAYLOAD_FLAG_O <= 1'b0;
            prev_sa               <= 32'h0;
            prev_info             <= 32'h0;
        end else if (byte_en) begin
            if (ev_start) begin
                DEST_ADDR_SEEN_O      <= 1'b0;
                SRC_ADDR_SEEN_O       <= 1'b0;
                INFO_FIELD_SEEN_O     <= 1'b0;
                DEST_MATCH_FLAG_O     <= 1'b0;
                SRC_MATCH_FLAG_O      <= 1'b0;
                REPEAT_SOURCE_FLAG_O  <= 1'b0;
                REPEAT_PAYLOAD_FLAG_O <= 1'b0;
            end
            if (ev_da_last) begin
                DEST_ADDR_SEEN_O     <= 1'b1;
                DEST_MATCH_FLAG_O    <= da_hit;
                SHORT_LONG_SELECT_O  <= addr_long;
                INDIV_GROUP_SELECT_O <= ~indiv;
            end
            if (ev_sa_last) begin
                SRC_ADDR_SEEN_O      <= 1'b1;
                SRC_MATCH_FLAG_O     <= sa_hit;
                REPEAT_SOURCE_FLAG_O <= !is_mac
                    && {addr_sh[23:0], d_in} == prev_sa;
                prev_sa              <= {addr_sh[23:0], d_in};
            end
            if (ev_info4) begin
                INFO_FIELD_SEEN_O     <= 1'b1;
                REPEAT_PAYLOAD_FLAG_O <= is_mac
                    && {info_sh[23:0], d_in} == prev_info;
                if (is_mac) prev_info <= {info_sh[23:0], d_in};
            end
        end
    end

    // crc over fc through fcs; residue checked at the delimiter
    logic [31:0] crc_r, crc_nxt;
    always_comb begin
        crc_nxt = crc_r ^ {24'h0, d_in};
        for (int i = 0; i < 8; i++) begin
            crc_nxt = crc_nxt[0] ? (crc_nxt >> 1) ^ mac_ind_pkg::CRC_POLY
                                 : crc_nxt >> 1;
        end
    end
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            crc_r <= mac_ind_pkg::CRC_INIT;
        end else if (byte_en) begin
            if (ev_start) crc_r <= mac_ind_pkg::CRC_INIT;
            else if (!c_in) crc_r <= crc_nxt;
        end
    end

    // R14: one termination event per pdu
    // R15: end delimiter through frame status
    // R16: token event with tt
    // R17: strip event on first idle
    // R18: fault event on faulty byte
    // R19: reset event on reset or stop
    // R20: length ok status
    // R21: crc residue status
    // R25: token shown as tt from the copy
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            TERM_O                <= '{ctrl_reset: 1'b1, default: 1'b0};
            LENGTH_OK_STATUS_O    <= 1'b0;
            CHECK_SEQ_OK_STATUS_O <= 1'b0;
        end else if (STOP_MODE_I) begin
            TERM_O <= '{ctrl_reset: 1'b1, default: 1'b0};
        end else if (byte_en) begin
            TERM_O.ctrl_reset   <= 1'b0;
            TERM_O.token_end    <= ev_tok;
            TERM_O.strip_end    <= ev_strip;
            TERM_O.format_fault <= ev_fault;
            TERM_O.end_delim    <= ev_ed || ev_fs;
            if (ev_ed) begin
                LENGTH_OK_STATUS_O <= len_r >= mac_ind_pkg::MIN_FRAME_LEN
                                      && !HALF_PAIR_I && !is_nt;
                CHECK_SEQ_OK_STATUS_O <= crc_r
                                         == mac_ind_pkg::CRC_RESIDUE;
            end
        end
    end

    // R22: external flags drive a and c indicators
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            A_IND_O <= 1'b0;
            C_IND_O <= 1'b0;
        end else if (byte_en) begin
            if (ev_start) begin
                A_IND_O <= 1'b0;
                C_IND_O <= 1'b0;
            end else if (ev_ed) begin
                A_IND_O <= DEST_MATCH_FLAG_O || EXT_ADDR_MATCH_IN_I;
                C_IND_O <= COPY_VALID_IN_I
                    && (DEST_MATCH_FLAG_O || EXT_ADDR_MATCH_IN_I);
            end
        end
    end

    // R24: parity checked as odd
    a_odd_parity: assert property (@(posedge CLK_I) disable iff (RESET_I)
        ^{IND_BYTE_O.parity, IND_BYTE_O.data} == 1'b1) // R24
        else $error("indication parity not odd");
    // R14: at most one termination event
    a_one_term: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $onehot0(TERM_O)) // R14
        else $error("more than one termination event");
    // R1: strobe every eight cycles
    a_byte_rate: assert property (@(posedge CLK_I) disable iff (RESET_I)
        BYTE_STROBE_O |=> !BYTE_STROBE_O [*7] ##1 BYTE_STROBE_O) // R1
        else $error("byte strobe rate wrong");
    // R2: data follows input
    a_data_copy: assert property (@(posedge CLK_I) disable iff (RESET_I)
        BYTE_STROBE_O |=> IND_BYTE_O.data == $past(PHY_BYTE_I.data)) // R2
        else $error("indication data not a copy");
    // R4: start strobe follows jk
    a_start_jk: assert property (@(posedge CLK_I) disable iff (RESET_I)
        RX_START_STROBE_O |-> IND_BYTE_O.data[7:4]
        == mac_ind_pkg::NIB_J) // R4
        else $error("start strobe without delimiter");
    // R6: dest seen cleared only by start
    a_dest_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
        DEST_ADDR_SEEN_O && !RX_START_STROBE_O && !STOP_MODE_I
        |=> DEST_ADDR_SEEN_O || RX_START_STROBE_O) // R6
        else $error("dest seen dropped early");
    // R16: token shows tt
    a_token_tt: assert property (@(posedge CLK_I) disable iff (RESET_I)
        TERM_O.token_end |-> IND_BYTE_O.data == 8'h55) // R16
        else $error("token event without tt");
    // R19: stop forces reset event
    a_stop_rst: assert property (@(posedge CLK_I) disable iff (RESET_I)
        STOP_MODE_I |=> TERM_O.ctrl_reset) // R19
        else $error("stop mode without reset event");

endmodule

`default_nettype wire

// *** mac_ind_pkg.sv ***
// package for the mac receive indication port: symbol codes,
// field lengths, reset values and the indication carrier struct.
// assumes one byte clock; no bus; all bits are plain ports.
package mac_ind_pkg;

    // byte time and clock rate
    localparam int BYTE_TIME_NS  = 80;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BYTE_CYCLES   = (BYTE_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam logic [3:0] DIV_LAST = 4'(BYTE_CYCLES - 1);

    // control symbol nibbles
    localparam logic [3:0] NIB_J    = 4'hd;
    localparam logic [3:0] NIB_T    = 4'h5;
    localparam logic [3:0] NIB_R    = 4'h6;
    localparam logic [3:0] NIB_S    = 4'h7;
    localparam logic [1:0] NIB_IDLE = 2'h2;

    // frame layout
    localparam logic [3:0] INFO_BYTES_CMP = 4'h4;
    localparam logic [3:0] SHORT_ADDR_LEN = 4'h2;
    localparam logic [3:0] LONG_ADDR_LEN  = 4'h6;
    localparam logic [11:0] MIN_FRAME_LEN = 12'h011;
    localparam logic [7:0] FC_MAC_MASK    = 8'hc0;
    localparam logic [7:0] FC_MAC_CODE    = 8'hc0;
    localparam int FC_LONG_BIT            = 6;

    // crc-32 residue over the check sequence
    localparam logic [31:0] CRC_POLY    = 32'hedb88320;
    localparam logic [31:0] CRC_INIT    = 32'hffffffff;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

    // reset values
    localparam logic [7:0]  DATA_RST  = 8'h00;
    localparam logic [3:0]  DIV_RST   = 4'h0;
    localparam logic [11:0] COUNT_RST = 12'h000;

    // byte from the phy side
    typedef struct packed {
        logic       ctrl;
        logic [7:0] data;
    } phy_byte_t;

    // indication data byte
    typedef struct packed {
        logic       parity;
        logic [7:0] data;
    } ind_byte_t;

    // termination events
    typedef struct packed {
        logic end_delim;
        logic token_end;
        logic strip_end;
        logic format_fault;
        logic ctrl_reset;
    } term_t;

    // receive sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_FC, ST_DA, ST_SA, ST_INFO, ST_STATUS
    } rx_state_t;

endpackage

// *** sys_copy_model.sv ***
// system interface side model: buffers indicated frame bytes and
// drives the external address and copy flags back to the port.
// assumes outputs of the port are stable across each byte time.
`timescale 1ns/1ps
`default_nettype none

module sys_copy_model (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // indication side
    input  wire logic                   strobe_i,
    input  wire logic                   start_i,
    input  wire logic                   fc_seen_i,
    input  wire mac_ind_pkg::term_t     term_i,
    input  wire mac_ind_pkg::ind_byte_t byte_i,
    // commands from the bench
    input  wire logic                   ext_req_i,
    input  wire logic                   copy_req_i,
    // flags and buffer fill
    output logic                        ext_o,
    output logic                        copy_o,
    output logic [7:0]                  n_buf_o
);
    logic       in_frame_r;
    logic [7:0] buf_q[$];

    // own buffering
    // copy every byte from fc to termination; the port keeps none
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_frame_r <= 1'b0;
            buf_q.delete();
        end else if (strobe_i) begin
            if (start_i) begin
                in_frame_r <= 1'b0;
                buf_q.delete();
            end else if (term_i != 5'h00) begin
                in_frame_r <= 1'b0;
            end else if (fc_seen_i || in_frame_r) begin
                in_frame_r <= 1'b1;
                buf_q.push_back(byte_i.data);
            end
        end
    end

    // external flags
    // levels follow the bench command, changed off the byte strobe
    always_ff @(posedge clk_i) begin
        ext_o  <= ext_req_i;
        copy_o <= copy_req_i;
    end

    assign n_buf_o = 8'(buf_q.size());
endmodule

`default_nettype wire

// *** mac_receive_indication_port_bench.sv ***
// self-checking bench for the receive indication port: sends
// tokens and frames byte by byte and compares every indication.
// assumes the byte strobe marks the edge that takes PHY_BYTE_I.
`timescale 1ns/1ps
`default_nettype none

module mac_receive_indication_port_bench;
    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic STOP_MODE_I = 1'b0, STRIP_I = 1'b0, HALF_PAIR_I = 1'b0;
    logic ext_req = 1'b0, copy_req = 1'b0, ext, copy;
    mac_ind_pkg::phy_byte_t PHY_BYTE_I = 9'h1aa;
    mac_ind_pkg::ind_byte_t IND_BYTE_O;
    mac_ind_pkg::term_t TERM_O;
    logic BYTE_STROBE_O, RX_START_STROBE_O, FRAME_CONTROL_SEEN_O;
    logic DEST_ADDR_SEEN_O, SRC_ADDR_SEEN_O, INFO_FIELD_SEEN_O;
    logic DEST_MATCH_FLAG_O, SRC_MATCH_FLAG_O, SHORT_LONG_SELECT_O;
    logic INDIV_GROUP_SELECT_O;
    logic REPEAT_SOURCE_FLAG_O, REPEAT_PAYLOAD_FLAG_O;
    logic LENGTH_OK_STATUS_O, CHECK_SEQ_OK_STATUS_O, A_IND_O, C_IND_O;
    logic [7:0] n_buf;
    localparam logic [47:0] LADDR = 48'h0a1b2c3d4e5f;
    localparam logic [15:0] SADDR = 16'h1357;
    localparam logic [47:0] OTHER = 48'h0123456789ab;
    localparam logic [47:0] GROUP = 48'h830000000001;
    int n_errors = 0, n_checks = 0, cyc = 0;

    always #5 CLK_I = ~CLK_I;

    mac_receive_indication_port mac_receive_indication_port_i (
        .CLK_I(CLK_I), .RESET_I(RESET_I), .PHY_BYTE_I(PHY_BYTE_I),
        .STOP_MODE_I(STOP_MODE_I), .STRIP_I(STRIP_I),
        .HALF_PAIR_I(HALF_PAIR_I), .LONG_ADDR_I(LADDR),
        .SHORT_ADDR_I(SADDR), .GROUP_ADDR_I(GROUP),
        .EXT_ADDR_MATCH_IN_I(ext), .COPY_VALID_IN_I(copy),
        .IND_BYTE_O(IND_BYTE_O), .BYTE_STROBE_O(BYTE_STROBE_O),
        .RX_START_STROBE_O(RX_START_STROBE_O),
        .FRAME_CONTROL_SEEN_O(FRAME_CONTROL_SEEN_O),
        .DEST_ADDR_SEEN_O(DEST_ADDR_SEEN_O),
        .SRC_ADDR_SEEN_O(SRC_ADDR_SEEN_O),
        .INFO_FIELD_SEEN_O(INFO_FIELD_SEEN_O),
        .DEST_MATCH_FLAG_O(DEST_MATCH_FLAG_O),
        .SRC_MATCH_FLAG_O(SRC_MATCH_FLAG_O),
        .SHORT_LONG_SELECT_O(SHORT_LONG_SELECT_O),
        .INDIV_GROUP_SELECT_O(INDIV_GROUP_SELECT_O),
        .REPEAT_SOURCE_FLAG_O(REPEAT_SOURCE_FLAG_O),
        .REPEAT_PAYLOAD_FLAG_O(REPEAT_PAYLOAD_FLAG_O), .TERM_O(TERM_O),
        .LENGTH_OK_STATUS_O(LENGTH_OK_STATUS_O),
        .CHECK_SEQ_OK_STATUS_O(CHECK_SEQ_OK_STATUS_O),
        .A_IND_O(A_IND_O), .C_IND_O(C_IND_O));

    sys_copy_model sys_copy_model_i (
        .clk_i(CLK_I), .rst_i(RESET_I), .strobe_i(BYTE_STROBE_O),
        .start_i(RX_START_STROBE_O), .fc_seen_i(FRAME_CONTROL_SEEN_O),
        .term_i(TERM_O), .byte_i(IND_BYTE_O), .ext_req_i(ext_req),
        .copy_req_i(copy_req), .ext_o(ext), .copy_o(copy),
        .n_buf_o(n_buf));

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(string n, logic [8:0] e, logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    // one byte per strobe; outputs land on the taking edge and are checked at the next negedge
    task automatic send(logic c, logic [7:0] d);
        int k;
        k = 0;
        while (BYTE_STROBE_O !== 1'b1 && k < 20) begin
            @(negedge CLK_I);
            k++;
        end
        PHY_BYTE_I = {c, d};
        @(negedge CLK_I);
        chk("ind_byte", {~^d, d}, IND_BYTE_O);
    endtask

    function automatic logic [31:0] crc(logic [31:0] c, logic [7:0] d);
        for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ ((c[0] ^ d[b]) ? mac_ind_pkg::CRC_POLY : 32'h0);
        return c;
    endfunction

    // exp and msk bits: dm sm rs rp lok fcs a c; fcs low corrupts
    task automatic frame(logic [7:0] fc, logic [47:0] da, sa, int ni,
                         logic [7:0] exp, msk);
        logic [7:0] q[$];
        logic [31:0] c;
        int al;
        al = fc[6] ? 6 : 2;
        q.push_back(fc);
        for (int i = al - 1; i >= 0; i--) q.push_back(da[8*i+:8]);
        for (int i = al - 1; i >= 0; i--) q.push_back(sa[8*i+:8]);
        for (int i = 0; i < ni; i++) q.push_back(8'(fc + i));
        c = mac_ind_pkg::CRC_INIT;
        foreach (q[i]) c = crc(c, q[i]);
        if (!exp[2]) c = c ^ 32'h1;
        for (int i = 0; i < 4; i++) q.push_back(~c[8*i+:8]);
        send(1'b1, 8'hdd);
        chk("start", 1'b1, RX_START_STROBE_O);
        foreach (q[i]) begin
            send(1'b0, q[i]);
            chk("fc_seen", i == 0, FRAME_CONTROL_SEEN_O);
            chk("da_seen", i >= al, DEST_ADDR_SEEN_O);
            chk("sa_seen", i >= 2*al, SRC_ADDR_SEEN_O);
            chk("info_seen", i >= 2*al+4, INFO_FIELD_SEEN_O);
            if (i == al) chk("sl_sel", fc[6], SHORT_LONG_SELECT_O);
            if (i == al)
                chk("ig_sel", da[8*al-1], INDIV_GROUP_SELECT_O);
            if (i == al && msk[7]) chk("dm", exp[7], DEST_MATCH_FLAG_O);
            if (i == 2*al && msk[6]) chk("sm", exp[6], SRC_MATCH_FLAG_O);
            if (i == 2*al && msk[5])
                chk("rs", exp[5], REPEAT_SOURCE_FLAG_O);
            if (i == 2*al+4 && msk[4])
                chk("rp", exp[4], REPEAT_PAYLOAD_FLAG_O);
        end
        send(1'b1, 8'h56);
        chk("ed_term", 5'b10000, TERM_O);
        if (msk[7]) chk("dm_hold", exp[7], DEST_MATCH_FLAG_O);
        if (msk[3]) chk("lok", exp[3], LENGTH_OK_STATUS_O);
        if (msk[2]) chk("fcs", exp[2], CHECK_SEQ_OK_STATUS_O);
        send(1'b1, 8'h66);
        chk("ed_stat", 5'b10000, TERM_O);
        if (msk[1]) chk("a_ind", exp[1], A_IND_O);
        if (msk[0]) chk("c_ind", exp[0], C_IND_O);
        send(1'b1, 8'haa);
    endtask

    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 10000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(negedge CLK_I);
        chk("rst_byte", 9'h100, IND_BYTE_O);
        chk("rst_term", 5'b00001, TERM_O);
        @(negedge CLK_I);
        RESET_I = 1'b0;
        send(1'b1, 8'hdd);
        send(1'b1, 8'h55);
        chk("tok", 5'b01000, TERM_O);
        copy_req = 1'b1;
        frame(8'h50, LADDR, 48'h00aa00bb00cc, 8, 8'h8f, 8'hdf);
        chk("buffered", 8'd25, n_buf);
        ext_req = 1'b1;
        frame(8'h50, OTHER, 48'h00aa00bb00cc, 8, 8'h2f, 8'hef);
        ext_req = 1'b0;
        copy_req = 1'b0;
        frame(8'h10, {32'h0, SADDR}, {32'h0, SADDR}, 4, 8'hc0, 8'hcd);
        copy_req = 1'b1;
        frame(8'hc2, GROUP, LADDR, 8, 8'hcf, 8'hcf);
        HALF_PAIR_I = 1'b1;
        frame(8'hc2, OTHER, LADDR, 8, 8'h54, 8'hdc);
        HALF_PAIR_I = 1'b0;
        STRIP_I = 1'b1;
        send(1'b1, 8'hdd);
        send(1'b0, 8'h50);
        send(1'b0, 8'h12);
        send(1'b1, 8'haa);
        chk("strip", 5'b00100, TERM_O);
        STRIP_I = 1'b0;
        send(1'b1, 8'hdd);
        send(1'b0, 8'h50);
        send(1'b1, 8'h44);
        chk("fmt", 5'b00010, TERM_O);
        STOP_MODE_I = 1'b1;
        send(1'b1, 8'haa);
        chk("stop", 5'b00001, TERM_O);
        conclude();
    end
endmodule

`default_nettype wire
